// File: mcar_regs.sv
`timescale 1ns/10ps
// How it works
// R01: mode register resets 100, bits 5:3 ones, bits 7:6 zero
// R02: mode bit 2 picks digital or analog
// R03: mode bit 1 picks talk or idle
// R04: mode bit 0 low forces sleep in digital operation
// R05: 001 follows slot pin: slot or receive
// R06: 000 gives analog slot mode always
// R07: digital operation ignores the slot pin
// R08: clock register upper bits reset to zero
// R09: clock bit 4 disables divided reference output
// R10: clock bit 3 selects weak reference driver
// R11: clock bit 2 selects divide by four
// R12: clock bits 1:0 select chip clock source
// R13: gain register bits 7 and 4 reset zero
// R14: bits 6:5 pick pdm range, 11 refused
// R15: gain bit 3 powers receive gain stage
// R16: gain bit 2 selects normal or reduced level
// R17: gain bits 1:0 select oscillator mode
// R18: soft reset write restores all reset values
// R19: master opens frames with 01 and identifier
// R20: direction, address, marker, eight data bits
// R21: new settings apply after last data bit
// R22: master writes reserved bits with reset values
module mcar_regs
#(
   parameter logic [5:0] P_SLAVE_IDENTIFIER = mcar_pkg::SLAVE_ID_DEFAULT
)
(
   // clock and reset
   input  wire logic       i_ref_clk,
   input  wire logic       i_nrst,
   // serial bus pins
   input  wire logic       i_ser_clk,
   input  wire logic       i_ser_stb_n,
   input  wire logic       i_ser_data,
   output logic            o_ser_data,
   output logic            o_ser_data_oe_n,
   // slot pin
   input  wire logic       i_slot_pin_n,
   // decoded operating state
   output logic            o_digital_mode,
   output logic            o_talk_active,
   output logic            o_sleep_active,
   output logic            o_analog_slot_mode,
   output logic            o_analog_rx_mode,
   // clock output controls
   output logic            o_ref_div_out_disable,
   output logic            o_ref_out_drive_weak,
   output logic            o_ref_div_ratio,
   output logic [1:0]      o_chip_clock_select,
   // gain and oscillator controls
   output logic [1:0]      o_agc_pdm_range,
   output logic            o_rx_gain_power_on,
   output logic            o_rx_osc_level,
   output logic [1:0]      o_rx_osc_mode
);
   import mcar_pkg::*;

   mcar_ser_if ser ();

   mcar_serial_sync u_sync
   (
      .i_ref_clk    (i_ref_clk),
      .i_nrst       (i_nrst),
      .i_ser_clk    (i_ser_clk),
      .i_ser_stb_n  (i_ser_stb_n),
      .i_ser_data   (i_ser_data),
      .i_slot_pin_n (i_slot_pin_n),
      .ser          (ser.src)
   );

   mcar_state_e state_q;
   mcar_state_e state_d;
   logic [3:0]  cnt_q;
   logic [3:0]  cnt_d;
   logic [7:0]  sh_q;
   logic [7:0]  sh_next;
   logic        dir_q;
   logic        dir_d;
   logic [6:0]  addr_q;
   logic [6:0]  addr_d;
   logic [7:0]  rd_byte_q;
   logic [7:0]  rd_byte_d;
   logic        wr_stb_q;
   logic        wr_stb_d;
   logic [7:0]  wdata_q;
   logic [7:0]  wdata_d;
   logic [6:0]  wr_addr_q;
   logic [7:0]  mode_q;
   logic [7:0]  clock_q;
   logic [7:0]  gain_q;
   logic [7:0]  rd_mux;
   logic [7:0]  gain_wr_val;
   logic [3:0]  cnt_inc;
   logic [3:0]  rd_idx;
   logic        wr_soft;
   logic        wr_mode;
   logic        wr_clock;
   logic        wr_gain;
   logic        drive_bit;
   logic        dig;
   logic        talk;
   logic        sleep_n;

   assign sh_next = {sh_q[6:0], ser.data_bit};
   assign cnt_inc = cnt_q + CNT_STEP;
   assign rd_idx  = CNT_DATA - cnt_q;

   // frame sequencer, advanced on each sampled rising bus clock
   always_comb
   begin
      state_d   = state_q;
      cnt_d     = cnt_q;
      dir_d     = dir_q;
      addr_d    = addr_q;
      rd_byte_d = rd_byte_q;
      wr_stb_d  = 1'b0;
      wdata_d   = wdata_q;
      if (!ser.frame_act)
         state_d = ST_IDLE;
      else if (state_q == ST_IDLE)
      begin
         state_d = ST_PREFIX;
         cnt_d   = CNT_ZERO;
      end
      else if (ser.clk_rise)
      begin
         cnt_d = cnt_inc;
         case (state_q)
            ST_PREFIX:
               if (cnt_q == CNT_PREFIX)
               begin
                  // anything but 01 silences us to frame end [R19]
                  state_d = (sh_next[1:0] == FRAME_PREFIX) ? ST_IDENT : ST_SKIP;
                  cnt_d   = CNT_ZERO;
               end
            ST_IDENT:
               if (cnt_q == CNT_IDENT)
                  state_d = (sh_next[5:0] == P_SLAVE_IDENTIFIER) ? ST_GAP : ST_SKIP;
            ST_GAP:
               state_d = ST_DIR;
            ST_DIR:
            begin
               dir_d   = ser.data_bit; // [R20]
               state_d = ST_ADDR;
               cnt_d   = CNT_ZERO;
            end
            ST_ADDR:
               if (cnt_q == CNT_ADDR)
               begin
                  addr_d  = sh_next[6:0]; // [R20]
                  state_d = ST_MARK;
               end
            ST_MARK:
            begin
               // read data is frozen here so a write cannot tear it
               rd_byte_d = rd_mux;
               state_d   = ST_DATA;
               cnt_d     = CNT_ZERO;
            end
            ST_DATA:
               if (cnt_q == CNT_DATA)
               begin
                  wr_stb_d = dir_q; // [R20] [R21]
                  wdata_d  = sh_next;
                  state_d  = ST_GAP;
               end
            ST_SKIP:
               state_d = ST_SKIP;
            default:
               state_d = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         state_q   <= ST_IDLE;
         cnt_q     <= CNT_ZERO;
         sh_q      <= RD_UNMAPPED;
         dir_q     <= 1'b0;
         addr_q    <= ADDR_SOFT_RESET;
         rd_byte_q <= RD_UNMAPPED;
      end
      else
      begin
         state_q   <= state_d;
         cnt_q     <= cnt_d;
         sh_q      <= ser.clk_rise ? sh_next : sh_q;
         dir_q     <= dir_d;
         addr_q    <= addr_d;
         rd_byte_q <= rd_byte_d;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         wr_stb_q  <= 1'b0;
         wdata_q   <= RD_UNMAPPED;
         wr_addr_q <= ADDR_SOFT_RESET;
      end
      else
      begin
         wr_stb_q  <= wr_stb_d;
         wdata_q   <= wdata_d;
         wr_addr_q <= wr_stb_d ? addr_q : wr_addr_q;
      end
   end

   // register decode
   assign wr_soft  = wr_stb_q && (wr_addr_q == ADDR_SOFT_RESET); // [R18]
   assign wr_mode  = wr_stb_q && (wr_addr_q == ADDR_MODE);
   assign wr_clock = wr_stb_q && (wr_addr_q == ADDR_CLOCK);
   assign wr_gain  = wr_stb_q && (wr_addr_q == ADDR_GAIN);

   // forbidden range code keeps the old range [R14]
   assign gain_wr_val = {wdata_q[7],
                         (wdata_q[6:5] == PDM_FORBIDDEN) ? gain_q[6:5] : wdata_q[6:5],
                         wdata_q[4:0]};

   assign rd_mux = (addr_q == ADDR_IDENT) ? {ID_PAD, P_SLAVE_IDENTIFIER} :
                   (addr_q == ADDR_MODE)  ? mode_q  :
                   (addr_q == ADDR_CLOCK) ? clock_q :
                   (addr_q == ADDR_GAIN)  ? gain_q  : RD_UNMAPPED;

   // reserved bits are stored as written and read back
   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         mode_q <= MODE_RST; // [R01] [R02] [R03] [R04]
      else if (wr_soft)
         mode_q <= MODE_RST; // [R18]
      else if (wr_mode)
         mode_q <= wdata_q; // [R21]
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         clock_q <= CLOCK_RST; // [R08] [R09] [R10] [R11] [R12]
      else if (wr_soft)
         clock_q <= CLOCK_RST; // [R18]
      else if (wr_clock)
         clock_q <= wdata_q; // [R21]
   end

   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         gain_q <= GAIN_RST; // [R13] [R14] [R15] [R16] [R17]
      else if (wr_soft)
         gain_q <= GAIN_RST; // [R18]
      else if (wr_gain)
         gain_q <= gain_wr_val; // [R21]
   end

   // read data goes out on the falling bus clock, held for the rise
   assign drive_bit = (state_q == ST_DATA) && !dir_q; // [R20]

   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_ser_data      <= 1'b1;
         o_ser_data_oe_n <= 1'b1;
      end
      else if (!ser.frame_act)
         o_ser_data_oe_n <= 1'b1;
      else if (ser.clk_fall)
      begin
         o_ser_data_oe_n <= !drive_bit;
         o_ser_data      <= drive_bit ? rd_byte_q[rd_idx[2:0]] : 1'b1;
      end
   end

   // operating state decode
   assign dig     = mode_q[MODE_DIGITAL_BIT];
   assign talk    = mode_q[MODE_TALK_BIT];
   assign sleep_n = mode_q[MODE_SLEEP_N_BIT];

   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
      begin
         o_digital_mode     <= 1'b1;
         o_talk_active      <= 1'b0;
         o_sleep_active     <= 1'b1;
         o_analog_slot_mode <= 1'b0;
         o_analog_rx_mode   <= 1'b0;
      end
      else
      begin
         o_digital_mode     <= dig; // [R02] [R07]
         o_talk_active      <= talk && (sleep_n || !dig); // [R03] [R04]
         o_sleep_active     <= dig && !sleep_n; // [R04]
         // slot pin only counts for 001 in analog operation
         o_analog_slot_mode <= !dig && !talk && (!sleep_n || !ser.slot_pin_n); // [R05] [R06] [R07]
         o_analog_rx_mode   <= !dig && !talk && sleep_n && ser.slot_pin_n; // [R05]
      end
   end

   assign o_ref_div_out_disable = clock_q[CLK_DIV_DIS_BIT]; // [R09]
   assign o_ref_out_drive_weak  = clock_q[CLK_DRV_WEAK_BIT]; // [R10]
   assign o_ref_div_ratio       = clock_q[CLK_DIV_RATIO_BIT]; // [R11]
   assign o_chip_clock_select   = clock_q[CLK_CHIP_LSB +: 2]; // [R12]
   assign o_agc_pdm_range       = gain_q[GAIN_PDM_LSB +: 2]; // [R14]
   assign o_rx_gain_power_on    = gain_q[GAIN_PWR_BIT]; // [R15]
   assign o_rx_osc_level        = gain_q[GAIN_LVL_BIT]; // [R16]
   assign o_rx_osc_mode         = gain_q[GAIN_OSC_LSB +: 2]; // [R17]

   sequence s_soft_write;
      wr_soft;
   endsequence

   sequence s_defaults;
      (mode_q == MODE_RST) && (clock_q == CLOCK_RST) && (gain_q == GAIN_RST);
   endsequence

   property p_soft_reset;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      s_soft_write |=> s_defaults;
   endproperty
   a_soft_reset: assert property (p_soft_reset) // [R18] [R01] [R08] [R13]
      else $error("soft reset did not restore defaults");

   property p_mode_write;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      wr_mode && !wr_soft |=> (mode_q == $past(wdata_q)) ##1 (o_digital_mode == mode_q[2]);
   endproperty
   a_mode_write: assert property (p_mode_write) // [R21] [R02]
      else $error("mode write not applied");

   property p_digital_ignores_slot;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      dig |=> !o_analog_slot_mode && !o_analog_rx_mode && o_digital_mode;
   endproperty
   a_digital_ignores_slot: assert property (p_digital_ignores_slot) // [R07]
      else $error("slot pin affected digital operation");

   property p_slot_forced;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      (mode_q[2:0] == MODE_ANALOG_SLOT) |=> o_analog_slot_mode;
   endproperty
   a_slot_forced: assert property (p_slot_forced) // [R06]
      else $error("000 did not give analog slot mode");

   property p_slot_pin;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      (mode_q[2:0] == MODE_ANALOG_SLOT_PIN) |=>
         (o_analog_slot_mode == !$past(ser.slot_pin_n)) && (o_analog_rx_mode == $past(ser.slot_pin_n));
   endproperty
   a_slot_pin: assert property (p_slot_pin) // [R05]
      else $error("001 did not follow the slot pin");

   property p_sleep;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      dig && !sleep_n |=> o_sleep_active && !o_talk_active;
   endproperty
   a_sleep: assert property (p_sleep) // [R04]
      else $error("sleep select did not force sleep");

   property p_talk;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      talk && sleep_n |=> o_talk_active && !o_sleep_active;
   endproperty
   a_talk: assert property (p_talk) // [R03]
      else $error("talk select not honoured");

   property p_pdm_refused;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      wr_gain && !wr_soft && (wdata_q[6:5] == PDM_FORBIDDEN) |=> $stable(gain_q[6:5]);
   endproperty
   a_pdm_refused: assert property (p_pdm_refused) // [R14]
      else $error("forbidden pdm range was stored");

   sequence s_read_bit;
      ser.frame_act && ser.clk_fall && drive_bit;
   endsequence

   property p_read_drive;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      s_read_bit |=> !o_ser_data_oe_n && (o_ser_data == $past(rd_byte_q[rd_idx[2:0]]));
   endproperty
   a_read_drive: assert property (p_read_drive) // [R20]
      else $error("read bit not driven");

   property p_release;
      @(posedge i_ref_clk) disable iff (!i_nrst)
      !ser.frame_act |=> o_ser_data_oe_n;
   endproperty
   a_release: assert property (p_release) // [R20]
      else $error("data line driven outside a frame");
endmodule

// File: mcar_pkg.sv
package mcar_pkg;

   // register addresses on the serial bus
   localparam logic [6:0] ADDR_SOFT_RESET = 7'h00;
   localparam logic [6:0] ADDR_IDENT      = 7'h01;
   localparam logic [6:0] ADDR_MODE       = 7'h04;
   localparam logic [6:0] ADDR_CLOCK      = 7'h09;
   localparam logic [6:0] ADDR_GAIN       = 7'h0C;

   // reset values
   localparam logic [7:0] MODE_RST        = 8'h3C;
   localparam logic [7:0] CLOCK_RST       = 8'h0C;
   localparam logic [7:0] GAIN_RST        = 8'h0B;
   localparam logic [7:0] RD_UNMAPPED     = 8'h00;
   localparam logic [1:0] ID_PAD          = 2'h0;

   // arbitrary identifier value, not taken from any part
   localparam logic [5:0] SLAVE_ID_DEFAULT = 6'h15;

   // operating mode control fields
   localparam int MODE_DIGITAL_BIT = 2;
   localparam int MODE_TALK_BIT    = 1;
   localparam int MODE_SLEEP_N_BIT = 0;
   localparam logic [2:0] MODE_ANALOG_SLOT_PIN = 3'h1;
   localparam logic [2:0] MODE_ANALOG_SLOT     = 3'h0;

   // clock output config fields
   localparam int CLK_DIV_DIS_BIT   = 4;
   localparam int CLK_DRV_WEAK_BIT  = 3;
   localparam int CLK_DIV_RATIO_BIT = 2;
   localparam int CLK_CHIP_LSB      = 0;

   // gain and oscillator control fields
   localparam int GAIN_PDM_LSB = 5;
   localparam int GAIN_PWR_BIT = 3;
   localparam int GAIN_LVL_BIT = 2;
   localparam int GAIN_OSC_LSB = 0;
   localparam logic [1:0] PDM_FORBIDDEN = 2'h3;

   // frame layout: last bit index of each field
   localparam logic [1:0] FRAME_PREFIX = 2'h1;
   localparam logic [3:0] CNT_PREFIX   = 4'h1;
   localparam logic [3:0] CNT_IDENT    = 4'h5;
   localparam logic [3:0] CNT_ADDR     = 4'h6;
   localparam logic [3:0] CNT_DATA     = 4'h7;
   localparam logic [3:0] CNT_ZERO     = 4'h0;
   localparam logic [3:0] CNT_STEP     = 4'h1;

   // idle levels of the synchronised pins: slot, data, strobe, clock
   localparam logic [3:0] SYNC_IDLE = 4'hF;
   localparam int PIN_CLK  = 0;
   localparam int PIN_STB  = 1;
   localparam int PIN_DATA = 2;
   localparam int PIN_SLOT = 3;

   typedef enum logic [3:0]
   {
      ST_IDLE,
      ST_PREFIX,
      ST_IDENT,
      ST_GAP,
      ST_DIR,
      ST_ADDR,
      ST_MARK,
      ST_DATA,
      ST_SKIP
   } mcar_state_e;

endpackage

// File: mcar_ser_if.sv
`timescale 1ns/10ps
interface mcar_ser_if;
   logic clk_rise;
   logic clk_fall;
   logic data_bit;
   logic frame_act;
   logic slot_pin_n;

   modport src
   (
      output clk_rise,
      output clk_fall,
      output data_bit,
      output frame_act,
      output slot_pin_n
   );

   modport sink
   (
      input clk_rise,
      input clk_fall,
      input data_bit,
      input frame_act,
      input slot_pin_n
   );
endinterface

// File: mcar_serial_sync.sv
`timescale 1ns/10ps
module mcar_serial_sync
(
   // clock and reset
   input  wire logic i_ref_clk,
   input  wire logic i_nrst,
   // raw pins
   input  wire logic i_ser_clk,
   input  wire logic i_ser_stb_n,
   input  wire logic i_ser_data,
   input  wire logic i_slot_pin_n,
   // synchronised view
   mcar_ser_if.src   ser
);
   import mcar_pkg::*;

   logic [3:0] raw;
   logic [3:0] meta_q;
   logic [3:0] sync_q;
   logic       clk_prev_q;

   assign raw = {i_slot_pin_n, i_ser_data, i_ser_stb_n, i_ser_clk};

   generate
      for (genvar g = 0; g < 4; g++)
      begin : g_sync
         always_ff @(posedge i_ref_clk or negedge i_nrst)
         begin
            if (!i_nrst)
            begin
               meta_q[g] <= SYNC_IDLE[g];
               sync_q[g] <= SYNC_IDLE[g];
            end
            else
            begin
               meta_q[g] <= raw[g];
               sync_q[g] <= meta_q[g];
            end
         end
      end
   endgenerate

   // edge history looks only at the second stage
   always_ff @(posedge i_ref_clk or negedge i_nrst)
   begin
      if (!i_nrst)
         clk_prev_q <= 1'b1;
      else
         clk_prev_q <= sync_q[PIN_CLK];
   end

   assign ser.clk_rise   = sync_q[PIN_CLK] & ~clk_prev_q;
   assign ser.clk_fall   = ~sync_q[PIN_CLK] & clk_prev_q;
   assign ser.data_bit   = sync_q[PIN_DATA];
   assign ser.frame_act  = ~sync_q[PIN_STB];
   assign ser.slot_pin_n = sync_q[PIN_SLOT];
endmodule

// File: mcar_master_model.sv
`timescale 1ns/10ps
module mcar_master_model
(
   // clock
   input  wire logic i_ref_clk,
   // bus pins
   input  wire logic i_line,
   output logic      o_ser_clk,
   output logic      o_ser_stb_n,
   output logic      o_drv_data,
   output logic      o_drv_en
);
   // bus clock half period in ref cycles, bench may slow it
   int half_cyc = 4;

   initial
   begin
      o_ser_clk   = 1'b1;
      o_ser_stb_n = 1'b1;
      o_drv_data  = 1'b1;
      o_drv_en    = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge i_ref_clk);
   endtask

   // nbits below a whole group count gives a frame cut short
   task automatic send(input logic [1:0] pfx, input logic [5:0] id, input logic [35:0] grp,
                       input int nbits, output logic [15:0] rd);
      logic [43:0] bits;
      int          pos;
      logic        rd_phase;
      bits = {pfx, id, grp};
      rd   = '0;
      tick(1);
      o_ser_stb_n = 1'b0;
      tick(half_cyc);
      for (int i = 0; i < 8 + nbits; i++)
      begin
         pos      = (i < 8) ? 0 : (i - 8) % 18;
         rd_phase = (i >= 8) && (pos >= 10) && !bits[42 - (i - pos)];
         o_ser_clk  = 1'b0;
         o_drv_en   = !rd_phase;
         o_drv_data = bits[43 - i];
         tick(half_cyc);
         o_ser_clk = 1'b1;
         tick(half_cyc);
         // sampled late in the high phase, device bit holds until next fall
         if (rd_phase)
            rd = {rd[14:0], i_line};
      end
      // line released, pull-up takes it high
      o_drv_en   = 1'b0;
      o_drv_data = 1'b1;
      tick(half_cyc);
      o_ser_stb_n = 1'b1;
      tick(3 * half_cyc);
   endtask
endmodule

// File: mode_clock_agc_regs_bench.sv
`timescale 1ns/10ps
module mode_clock_agc_regs_bench;
   import mcar_pkg::*;

   // arbitrary identifier value
   localparam logic [5:0] BENCH_ID = 6'h2A;
   localparam logic [7:0] M0       = 8'h3C;
   localparam logic [7:0] C0       = 8'h0C;
   localparam logic [7:0] G0       = 8'h0B;

   logic        i_ref_clk;
   logic        i_nrst;
   logic        i_slot_pin_n;
   logic        line;
   logic        drv_data, drv_en, ser_clk, ser_stb_n;
   logic        o_ser_data, o_ser_data_oe_n;
   logic        o_digital_mode, o_talk_active, o_sleep_active;
   logic        o_analog_slot_mode, o_analog_rx_mode;
   logic        o_ref_div_out_disable, o_ref_out_drive_weak, o_ref_div_ratio;
   logic [1:0]  o_chip_clock_select, o_agc_pdm_range, o_rx_osc_mode;
   logic        o_rx_gain_power_on, o_rx_osc_level;
   logic [15:0] rd;
   int          n_errors = 0;
   int          checked  = 0;

   assign line = !o_ser_data_oe_n ? o_ser_data : (drv_en ? drv_data : 1'b1);

   initial
   begin
      i_ref_clk = 1'b0;
      forever #2 i_ref_clk = !i_ref_clk;
   end

   mcar_regs #(.P_SLAVE_IDENTIFIER(BENCH_ID)) u_dut
   (
      .i_ref_clk             (i_ref_clk),
      .i_nrst                (i_nrst),
      .i_ser_clk             (ser_clk),
      .i_ser_stb_n           (ser_stb_n),
      .i_ser_data            (line),
      .o_ser_data            (o_ser_data),
      .o_ser_data_oe_n       (o_ser_data_oe_n),
      .i_slot_pin_n          (i_slot_pin_n),
      .o_digital_mode        (o_digital_mode),
      .o_talk_active         (o_talk_active),
      .o_sleep_active        (o_sleep_active),
      .o_analog_slot_mode    (o_analog_slot_mode),
      .o_analog_rx_mode      (o_analog_rx_mode),
      .o_ref_div_out_disable (o_ref_div_out_disable),
      .o_ref_out_drive_weak  (o_ref_out_drive_weak),
      .o_ref_div_ratio       (o_ref_div_ratio),
      .o_chip_clock_select   (o_chip_clock_select),
      .o_agc_pdm_range       (o_agc_pdm_range),
      .o_rx_gain_power_on    (o_rx_gain_power_on),
      .o_rx_osc_level        (o_rx_osc_level),
      .o_rx_osc_mode         (o_rx_osc_mode)
   );

   mcar_master_model u_master
   (
      .i_ref_clk   (i_ref_clk),
      .i_line      (line),
      .o_ser_clk   (ser_clk),
      .o_ser_stb_n (ser_stb_n),
      .o_drv_data  (drv_data),
      .o_drv_en    (drv_en)
   );

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   function automatic logic [17:0] grp(input logic dir, input logic [6:0] a, input logic [7:0] d);
      return {1'b1, dir, a, 1'b1, d};
   endfunction

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      u_master.send(FRAME_PREFIX, BENCH_ID, {grp(1'b1, a, d), 18'h0}, 18, rd);
   endtask

   task automatic rdchk(input string name, input logic [6:0] a, input logic [7:0] exp);
      u_master.send(FRAME_PREFIX, BENCH_ID, {grp(1'b0, a, 8'h00), 18'h0}, 18, rd);
      chk(name, exp, rd[7:0]);
      chk("oe_n", 8'h01, {7'h0, o_ser_data_oe_n});
   endtask

   // reads back all three registers, then every control output
   task automatic all(input logic [7:0] m, input logic [7:0] c, input logic [7:0] g);
      logic d;
      d = m[2];
      rdchk("mode", ADDR_MODE, m);
      rdchk("clock", ADDR_CLOCK, c);
      rdchk("gain", ADDR_GAIN, g);
      chk("decoded", {3'h0, d, d ? m[1] & m[0] : m[1],
          d & !m[0], !d & !m[1] & (!m[0] | !i_slot_pin_n), !d & !m[1] & m[0] & i_slot_pin_n},
          {3'h0, o_digital_mode, o_talk_active, o_sleep_active, o_analog_slot_mode,
          o_analog_rx_mode});
      chk("clock_out", {3'h0, c[4:0]},
          {3'h0, o_ref_div_out_disable, o_ref_out_drive_weak, o_ref_div_ratio,
          o_chip_clock_select});
      chk("gain_out", g & 8'h6F,
          {1'b0, o_agc_pdm_range, 1'b0, o_rx_gain_power_on, o_rx_osc_level,
          o_rx_osc_mode});
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   localparam logic [7:0] CLK_V [4]  = '{8'h00, 8'h1D, 8'h0A, 8'h17};
   localparam logic [7:0] GAIN_V [4] = '{8'h00, 8'h2D, 8'h0B, 8'h4E};

   initial
   begin
      i_nrst       = 1'b0;
      i_slot_pin_n = 1'b1;
      repeat (4) @(negedge i_ref_clk);
      i_nrst = 1'b1;
      repeat (3) @(negedge i_ref_clk);
      all(M0, C0, G0);
      rdchk("ident", ADDR_IDENT, {2'h0, BENCH_ID});
      for (int k = 0; k < 8; k++)
      begin
         wr(ADDR_MODE, 8'h38 | k[7:0]);
         for (int s = 0; s < 2; s++)
         begin
            i_slot_pin_n = s[0];
            repeat (8) @(negedge i_ref_clk);
            all(8'h38 | k[7:0], C0, G0);
         end
      end
      for (int i = 0; i < 4; i++)
      begin
         wr(ADDR_CLOCK, CLK_V[i]);
         wr(ADDR_GAIN, GAIN_V[i]);
         all(8'h3F, CLK_V[i], GAIN_V[i]);
      end
      // forbidden range code keeps the old range, other bits still land
      wr(ADDR_GAIN, 8'h69);
      all(8'h3F, 8'h17, 8'h49);
      // slow bus, write then read back in one frame
      u_master.half_cyc = 8;
      u_master.send(FRAME_PREFIX, BENCH_ID, {grp(1'b1, ADDR_CLOCK, 8'h09),
                    grp(1'b0, ADDR_CLOCK, 8'h00)}, 36, rd);
      chk("b2b", 8'h09, rd[7:0]);
      u_master.half_cyc = 4;
      u_master.send(2'h2, BENCH_ID, {grp(1'b1, ADDR_MODE, 8'h3B), 18'h0}, 18, rd);
      u_master.send(FRAME_PREFIX, ~BENCH_ID, {grp(1'b1, ADDR_MODE, 8'h3B), 18'h0},
                    18, rd);
      u_master.send(FRAME_PREFIX, BENCH_ID, {grp(1'b1, ADDR_MODE, 8'h3B), 18'h0}, 15, rd);
      wr(ADDR_IDENT, 8'hFF);
      wr(7'h02, 8'hFF);
      rdchk("unmapped", 7'h02, 8'h00);
      rdchk("ident", ADDR_IDENT, {2'h0, BENCH_ID});
      all(8'h3F, 8'h09, 8'h49);
      wr(ADDR_SOFT_RESET, 8'h00);
      all(M0, C0, G0);
      give_verdict();
   end

   initial
   begin
      // tests need about 24k clocks; allow roughly twice that
      #200000;
      n_errors++;
      $display("watchdog expired");
      give_verdict();
   end
endmodule
